// ---- rtl/spdc_core.v ----
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "spdc_defs.vh"
// =====================================================================
// serial port DMA, CRC and status logic
module spdc_core (
   input wire sys_clk,
   input wire rst,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   input wire sck_pin,
   input wire nss_pin,
   input wire miso_pin,
   input wire mosi_pin,
   output reg mosi_out,
   output reg mosi_oe,
   output reg miso_out,
   output reg miso_oe,
   output reg sck_out,
   output reg sck_oe,
   output reg nss_out,
   output reg nss_oe,
   output wire tx_dma_req,
   output wire rx_dma_req,
   output wire irq
);
   // =====================================================================
   // registers
   reg [15:0] ctl0_reg;
   reg [15:0] ctl1_reg;
   reg [15:0] poly_reg;
   reg [15:0] txbuf_reg;
   reg [15:0] rxbuf_reg;
   reg [15:0] tcrc_reg;
   reg [15:0] rcrc_reg;
   reg [15:0] shtx_reg;
   reg [15:0] shrx_reg;
   reg [4:0] bitcnt_reg;
   reg [7:0] div_reg;
   reg tx_buf_empty_flag;
   reg rx_buf_full_flag;
   reg crc_mismatch_flag;
   reg config_fault_flag;
   reg rx_overrun_flag;
   reg frame_format_error_flag;
   reg transfer_active_flag;
   reg stat_seen_reg;
   reg data_rd_seen_reg;
   reg crc_phase_reg;
   reg crc_armed_reg;
   // set from the first sampled bit of a slave frame to its last;
   // outside it a selected slave may still reload its shifter
   reg frame_open_reg;
   reg [2:0] sck_sync_reg;
   reg [2:0] nss_sync_reg;
   reg [1:0] mosi_sync_reg;
   reg [1:0] miso_sync_reg;

   wire port_enable_bit = ctl0_reg[`SPDC_C0_EN];
   wire master_select_bit = ctl0_reg[`SPDC_C0_MSTR];
   wire soft_select_level = ctl0_reg[`SPDC_C0_SWLVL];
   wire soft_select_mode = ctl0_reg[`SPDC_C0_SWSEL];
   wire rx_only = ctl0_reg[`SPDC_C0_RXONLY] | (ctl0_reg[`SPDC_C0_BIDIR] & ~ctl0_reg[14]);
   wire wide_frame = ctl0_reg[`SPDC_C0_F16];
   wire crc_send_next = ctl0_reg[`SPDC_C0_CRCNX];
   wire crc_calc_en = ctl0_reg[`SPDC_C0_CRC_CALC_EN];
   wire rx_dma_req_en = ctl1_reg[`SPDC_C1_RXDMA];
   wire tx_dma_req_en = ctl1_reg[`SPDC_C1_TXDMA];
   wire select_output_drive_en = ctl1_reg[`SPDC_C1_SELDRV];
   wire header_mode = ctl1_reg[`SPDC_C1_HDRMODE];
   wire error_irq_en = ctl1_reg[`SPDC_C1_ERROR_IRQ_EN];
   wire rx_full_irq_en = ctl1_reg[`SPDC_C1_RXIE];
   wire tx_empty_irq_en = ctl1_reg[`SPDC_C1_TXIE];

   // =====================================================================
   // pin synchronisers; first stage read only by the second
   wire sck_s = sck_sync_reg[1];
   wire nss_s = nss_sync_reg[1];
   wire sck_rise_slv = sck_sync_reg[1] & ~sck_sync_reg[2];
   wire sck_fall_slv = ~sck_sync_reg[1] & sck_sync_reg[2];
   wire nss_edge = nss_sync_reg[1] ^ nss_sync_reg[2];
   always @(posedge sys_clk) begin
      if (rst) begin
         sck_sync_reg <= 3'h0;
         nss_sync_reg <= 3'h7;
         mosi_sync_reg <= 2'h0;
         miso_sync_reg <= 2'h0;
      end else begin
         sck_sync_reg <= {sck_sync_reg[1:0], sck_pin};
         nss_sync_reg <= {nss_sync_reg[1:0], nss_pin};
         mosi_sync_reg <= {mosi_sync_reg[0], mosi_pin};
         miso_sync_reg <= {miso_sync_reg[0], miso_pin};
      end
   end

   // =====================================================================
   // bit timing: master makes its clock by a divider, slave follows the pin
   wire [4:0] frame_bits = wide_frame ? 5'h10 : 5'h08;
   wire master_go = master_select_bit & port_enable_bit;
   wire div_tick = (div_reg == 8'h03);
   wire m_sample = master_go & transfer_active_flag & div_tick & ~sck_out;
   wire m_shift = master_go & transfer_active_flag & div_tick & sck_out;
   wire slave_sel = ~master_select_bit & ~nss_s;
   // slave engines run on the pin clock even with the port off
   wire s_sample = slave_sel & sck_rise_slv;
   wire s_shift = slave_sel & sck_fall_slv;
   wire sample = m_sample | s_sample;
   wire shift = m_shift | s_shift;
   wire rx_bit = master_select_bit ? miso_sync_reg[1] : mosi_sync_reg[1];
   wire tx_bit = wide_frame ? shtx_reg[15] : shtx_reg[7];
   wire last_bit = (bitcnt_reg == frame_bits - 5'h01);
   wire frame_done = sample & last_bit;
   wire [15:0] rx_word = wide_frame ? {shrx_reg[14:0], rx_bit} : {8'h00, shrx_reg[6:0], rx_bit};
   wire crc_due = crc_send_next | ((tx_dma_req_en | rx_dma_req_en) & crc_armed_reg);

   // serial CRC step with programmable polynomial
   function [15:0] crc_step;
      input [15:0] crc;
      input b;
      input f16;
      reg fb;
      begin
         fb = (f16 ? crc[15] : crc[7]) ^ b;
         crc_step = {crc[14:0], 1'b0} ^ (fb ? poly_reg : 16'h0000);
         if (!f16) begin
            crc_step[15:8] = 8'h00;
         end
      end
   endfunction

   // =====================================================================
   // register bus decode
   wire wr_ctl0 = reg_wr & (reg_addr == `SPDC_CTL0_ADDR);
   wire wr_ctl1 = reg_wr & (reg_addr == `SPDC_CTL1_ADDR);
   wire wr_stat = reg_wr & (reg_addr == `SPDC_STAT_ADDR);
   wire rd_stat = reg_rd & (reg_addr == `SPDC_STAT_ADDR);
   wire wr_data = reg_wr & (reg_addr == `SPDC_DATA_ADDR);
   wire rd_data = reg_rd & (reg_addr == `SPDC_DATA_ADDR);
   wire wr_poly = reg_wr & (reg_addr == `SPDC_POLY_ADDR);
   // master fault sources
   wire fault_hw = ~soft_select_mode & ~select_output_drive_en & ~nss_s;
   wire fault_sw = soft_select_mode & ~soft_select_level;
   wire fault_set = master_select_bit & (fault_hw | fault_sw);

   wire [15:0] status_word = {7'h00, frame_format_error_flag, transfer_active_flag, rx_overrun_flag,
      config_fault_flag, crc_mismatch_flag, 2'h0, tx_buf_empty_flag, rx_buf_full_flag};

   always @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `SPDC_CTL0_ADDR: reg_rdata <= ctl0_reg;
            `SPDC_CTL1_ADDR: reg_rdata <= ctl1_reg;
            `SPDC_STAT_ADDR: reg_rdata <= status_word;
            `SPDC_DATA_ADDR: reg_rdata <= rxbuf_reg;
            `SPDC_POLY_ADDR: reg_rdata <= poly_reg;
            `SPDC_RCRC_ADDR: reg_rdata <= rcrc_reg;
            `SPDC_TCRC_ADDR: reg_rdata <= tcrc_reg;
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // =====================================================================
   // control registers
   always @(posedge sys_clk) begin
      if (rst) begin
         ctl0_reg <= `SPDC_CTL0_RST;
         ctl1_reg <= `SPDC_CTL1_RST;
         poly_reg <= `SPDC_POLY_RST;
      end else begin
         if (wr_ctl0) begin
            ctl0_reg <= reg_wdata;
            if (config_fault_flag && !(stat_seen_reg)) begin
               // protected bits keep their value during the fault until the status register has been accessed
               ctl0_reg[`SPDC_C0_EN] <= ctl0_reg[`SPDC_C0_EN];
               ctl0_reg[`SPDC_C0_MSTR] <= ctl0_reg[`SPDC_C0_MSTR];
            end
         end else if (crc_phase_reg && frame_done) begin
            ctl0_reg[`SPDC_C0_CRCNX] <= 1'b0;
         end
         if (fault_set) begin
            ctl0_reg[`SPDC_C0_EN] <= 1'b0;
            ctl0_reg[`SPDC_C0_MSTR] <= 1'b0;
         end
         if (wr_ctl1) begin
            ctl1_reg <= reg_wdata;
         end
         if (wr_poly) begin
            poly_reg <= reg_wdata;
         end
      end
   end

   // =====================================================================
   // shifting, buffers and CRC
   always @(posedge sys_clk) begin
      if (rst) begin
         txbuf_reg <= 16'h0000;
         rxbuf_reg <= 16'h0000;
         shtx_reg <= 16'h0000;
         shrx_reg <= 16'h0000;
         tcrc_reg <= 16'h0000;
         rcrc_reg <= 16'h0000;
         bitcnt_reg <= 5'h00;
         div_reg <= 8'h00;
         sck_out <= 1'b0;
         tx_buf_empty_flag <= 1'b1;
         rx_buf_full_flag <= 1'b0;
         transfer_active_flag <= 1'b0;
         crc_phase_reg <= 1'b0;
         crc_armed_reg <= 1'b0;
         frame_open_reg <= 1'b0;
         rx_overrun_flag <= 1'b0;
         crc_mismatch_flag <= 1'b0;
      end else begin
         div_reg <= (master_go && transfer_active_flag && !div_tick) ? div_reg + 8'h01 : 8'h00;
         if (div_tick && master_go && transfer_active_flag) begin
            sck_out <= ~sck_out;
         end
         if (wr_data) begin
            txbuf_reg <= reg_wdata;
            tx_buf_empty_flag <= 1'b0;
         end
         // start a frame: master when data waits, a crc is due or receive-only, slave when selected
         // a slave held selected between frames restarts at once, so the
         // shifter may be loaded again until the next frame's first bit;
         // this lets a late send-crc-next still put the crc on the line
         if (port_enable_bit &&
               ((!transfer_active_flag && ((master_go && (!tx_buf_empty_flag || rx_only || crc_due)) || slave_sel)) ||
               (transfer_active_flag && slave_sel && !frame_open_reg))) begin
            transfer_active_flag <= 1'b1;
            bitcnt_reg <= 5'h00;
            if (crc_due && !crc_phase_reg) begin
               shtx_reg <= tcrc_reg;
               crc_phase_reg <= 1'b1;
            end else if (!tx_buf_empty_flag) begin
               shtx_reg <= txbuf_reg;
               tx_buf_empty_flag <= ~wr_data;
            end
         end
         if (shift) begin
            shtx_reg <= {shtx_reg[14:0], 1'b0};
         end
         if (crc_calc_en) begin
            // the received crc frame is held out of the engine so that
            // its last value is the one to compare against
            if (sample && !crc_phase_reg) begin
               rcrc_reg <= crc_step(rcrc_reg, rx_bit, wide_frame);
            end
            // the shift edge still sees the bit just sent, so each bit
            // enters the engine exactly once
            if (shift) begin
               tcrc_reg <= crc_step(tcrc_reg, tx_bit, wide_frame);
            end
         end else begin
            tcrc_reg <= 16'h0000;
            rcrc_reg <= 16'h0000;
         end
         if (sample) begin
            frame_open_reg <= ~last_bit;
            shrx_reg <= {shrx_reg[14:0], rx_bit};
            bitcnt_reg <= last_bit ? 5'h00 : bitcnt_reg + 5'h01;
         end
         if (frame_done) begin
            transfer_active_flag <= slave_sel & ~port_enable_bit;
            if (crc_phase_reg) begin
               // frame alongside our own CRC is the received CRC
               crc_phase_reg <= 1'b0;
               crc_armed_reg <= 1'b0;
               if (rcrc_reg != rx_word) begin
                  crc_mismatch_flag <= 1'b1;
               end
            end else if (rx_buf_full_flag && !rd_data) begin
               rx_overrun_flag <= 1'b1;
            end else if (port_enable_bit) begin
               rxbuf_reg <= rx_word;
               rx_buf_full_flag <= 1'b1;
               crc_armed_reg <= tx_buf_empty_flag & crc_calc_en;
            end
         end else if (rd_data) begin
            rx_buf_full_flag <= 1'b0;
         end
         // =====================================================================
         // slave deselect ends any transfer and realigns the bit count;
         // without it a cut frame would leave the next one misaligned
         if (!master_select_bit && nss_s) begin
            transfer_active_flag <= 1'b0;
            bitcnt_reg <= 5'h00;
            frame_open_reg <= 1'b0;
         end
         if (rd_stat && data_rd_seen_reg && !(frame_done && rx_buf_full_flag)) begin
            rx_overrun_flag <= 1'b0;
         end
         if (wr_stat && !reg_wdata[`SPDC_ST_CRC_MISMATCH_FLAG] && !(frame_done && crc_phase_reg)) begin
            crc_mismatch_flag <= 1'b0;
         end
      end
   end

   // =====================================================================
   // fault, format error and clear sequences
   always @(posedge sys_clk) begin
      if (rst) begin
         config_fault_flag <= 1'b0;
         frame_format_error_flag <= 1'b0;
         stat_seen_reg <= 1'b0;
         data_rd_seen_reg <= 1'b0;
      end else begin
         if (rd_stat || wr_stat) begin
            stat_seen_reg <= config_fault_flag;
         end else if (wr_ctl0) begin
            stat_seen_reg <= 1'b0;
         end
         if (rd_data) begin
            data_rd_seen_reg <= 1'b1;
         end else if (rd_stat) begin
            data_rd_seen_reg <= 1'b0;
         end
         if (fault_set) begin
            config_fault_flag <= 1'b1;
         end else if (wr_ctl0 && stat_seen_reg) begin
            config_fault_flag <= 1'b0;
         end
         // select moving while bits of a byte are still due
         if (header_mode && !master_select_bit && nss_edge && bitcnt_reg != 5'h00) begin
            frame_format_error_flag <= 1'b1;
         end else if (wr_stat && !reg_wdata[`SPDC_ST_FRAME_FORMAT_ERROR_FLAG]) begin
            frame_format_error_flag <= 1'b0;
         end
      end
   end

   // =====================================================================
   // pin drive
   always @(posedge sys_clk) begin
      if (rst) begin
         mosi_out <= 1'b0;
         mosi_oe <= 1'b0;
         miso_out <= 1'b0;
         miso_oe <= 1'b0;
         sck_oe <= 1'b0;
         nss_out <= 1'b1;
         nss_oe <= 1'b0;
      end else begin
         mosi_out <= tx_bit;
         mosi_oe <= master_go & ~rx_only;
         miso_out <= tx_bit;
         miso_oe <= slave_sel & port_enable_bit & ~rx_only;
         sck_oe <= master_go;
         nss_out <= ~transfer_active_flag;
         nss_oe <= master_go & select_output_drive_en;
      end
   end

   assign tx_dma_req = tx_dma_req_en & port_enable_bit & tx_buf_empty_flag;
   assign rx_dma_req = rx_dma_req_en & port_enable_bit & rx_buf_full_flag;
   // active-state flag deliberately left out of the request
   assign irq = (tx_empty_irq_en & tx_buf_empty_flag) | (rx_full_irq_en & rx_buf_full_flag) |
      (error_irq_en & (config_fault_flag | rx_overrun_flag | crc_mismatch_flag |
      frame_format_error_flag));
   wire unused_ok = sck_s;
endmodule // spdc_core

// ---- rtl/spdc_defs.vh ----
`ifndef SPDC_DEFS_VH
`define SPDC_DEFS_VH

// register offsets
`define SPDC_CTL0_ADDR 4'h0
`define SPDC_CTL1_ADDR 4'h1
`define SPDC_STAT_ADDR 4'h2
`define SPDC_DATA_ADDR 4'h3
`define SPDC_POLY_ADDR 4'h4
`define SPDC_RCRC_ADDR 4'h5
`define SPDC_TCRC_ADDR 4'h6

// first control register fields
`define SPDC_C0_MSTR 2
`define SPDC_C0_EN 6
`define SPDC_C0_SWLVL 8
`define SPDC_C0_SWSEL 9
`define SPDC_C0_RXONLY 10
`define SPDC_C0_F16 11
`define SPDC_C0_CRCNX 12
`define SPDC_C0_CRC_CALC_EN 13
`define SPDC_C0_BIDIR 15
// second control register fields
`define SPDC_C1_RXDMA 0
`define SPDC_C1_TXDMA 1
`define SPDC_C1_SELDRV 2
`define SPDC_C1_HDRMODE 4
`define SPDC_C1_ERROR_IRQ_EN 5
`define SPDC_C1_RXIE 6
`define SPDC_C1_TXIE 7
// status fields
`define SPDC_ST_RXF 0
`define SPDC_ST_TXE 1
`define SPDC_ST_CRC_MISMATCH_FLAG 4
`define SPDC_ST_CFGF 5
`define SPDC_ST_OVR 6
`define SPDC_ST_ACT 7
`define SPDC_ST_FRAME_FORMAT_ERROR_FLAG 8

// reset values
`define SPDC_CTL0_RST 16'h0000
`define SPDC_CTL1_RST 16'h0000
`define SPDC_POLY_RST 16'h0007
`endif

// ---- sim/spdc_core_properties.sv ----
`timescale 1ns/1ps
`include "spdc_defs.vh"
// ==========
// port checks
module spdc_core_chk (
   input wire sys_clk,
   input wire rst,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   input wire tx_dma_req,
   input wire rx_dma_req,
   input wire irq
);
   reg [15:0] c1_reg;
   wire wr_data = reg_wr && reg_addr == `SPDC_DATA_ADDR;
   wire rd_data = reg_rd && reg_addr == `SPDC_DATA_ADDR;
   wire rd_stat = reg_rd && reg_addr == `SPDC_STAT_ADDR;
   // hardware never alters ctl1, so this shadow is exact
   always @(posedge sys_clk) begin
      if (rst) begin
         c1_reg <= `SPDC_CTL1_RST;
      end else if (reg_wr && reg_addr == `SPDC_CTL1_ADDR) begin
         c1_reg <= reg_wdata;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_tx_req_clear: assert property (wr_data |=> !tx_dma_req)
      else $error("tx request high after data write");
   a_rx_req_clear: assert property (rd_data |=> !rx_dma_req)
      else $error("rx request high after data read");
   a_tx_req_gate: assert property (tx_dma_req |-> c1_reg[`SPDC_C1_TXDMA])
      else $error("tx request without its enable");
   a_rx_req_gate: assert property (rx_dma_req |-> c1_reg[`SPDC_C1_RXDMA])
      else $error("rx request without its enable");
   a_tx_irq_path: assert property (tx_dma_req && c1_reg[`SPDC_C1_TXIE] |-> irq)
      else $error("tx empty not raising irq");
   a_rx_irq_path: assert property (rx_dma_req && c1_reg[`SPDC_C1_RXIE] |-> irq)
      else $error("rx full not raising irq");
   a_irq_masked: assert property (!c1_reg[7] && !c1_reg[6] && !c1_reg[5] |-> !irq)
      else $error("irq with all enables off");
   a_stat_txe: assert property (rd_stat && tx_dma_req |=> reg_rdata[`SPDC_ST_TXE])
      else $error("status misses tx empty");
   a_stat_rxf: assert property (rd_stat && rx_dma_req |=> reg_rdata[`SPDC_ST_RXF])
      else $error("status misses rx full");
   a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read cycle");
endmodule // spdc_core_chk

bind spdc_core spdc_core_chk i_spdc_core_chk (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .irq(irq));

// ---- sim/spdc_ext_master.sv ----
`timescale 1ns/1ps
// ==========
// far-side serial master, 200 ns link clock
module spdc_ext_master (
   output reg link_sck,
   output reg link_sel_n,
   output reg link_mosi,
   input wire link_miso
);
   initial begin
      link_sck = 1'b0;
      link_sel_n = 1'b1;
      link_mosi = 1'b0;
   end
   // nbits below 8 aborts mid byte; keep holds select low for a crc frame
   task frame(input [7:0] d, input integer nbits, input keep, output [7:0] q);
      integer i;
      begin
         q = 8'h00;
         // keep link edges off the system clock edges
         #3;
         link_sel_n = 1'b0;
         #200;
         for (i = 7; i > 7 - nbits; i = i - 1) begin
            link_mosi = d[i];
            #100 link_sck = 1'b1;
            // slave output moves only after the falling edge, so take it late
            #100 q[i] = link_miso;
            link_sck = 1'b0;
         end
         #100;
         link_sel_n = !keep;
         link_mosi = ~link_mosi;
      end
   endtask
endmodule // spdc_ext_master

// ---- sim/tb_spi_dma_crc_status_logic.sv ----
`timescale 1ns/1ps
`include "spdc_defs.vh"
// ==========
// bench
module tb_spi_dma_crc_status_logic;
   reg sys_clk;
   reg rst;
   reg [3:0] reg_addr;
   reg [15:0] reg_wdata;
   reg reg_wr;
   reg reg_rd;
   reg flip;
   reg [7:0] q;
   wire [15:0] reg_rdata;
   wire sck, sel_n, mosi, mosi_out, mosi_oe, miso_out, miso_oe;
   wire sck_out, sck_oe, nss_out, nss_oe, tx_dma_req, rx_dma_req, irq;
   wire miso_w = miso_oe ? miso_out : flip;
   integer n_mismatch;
   integer num_checks;
   integer cyc;
   spdc_core i_spdc_core (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_pin(sck_oe ? sck_out : sck),
      .nss_pin(nss_oe ? nss_out : sel_n), .miso_pin(miso_w), .mosi_pin(mosi_oe ? mosi_out : mosi),
      .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe),
      .sck_out(sck_out), .sck_oe(sck_oe), .nss_out(nss_out), .nss_oe(nss_oe),
      .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .irq(irq));
   spdc_ext_master i_spdc_ext_master (.link_sck(sck), .link_sel_n(sel_n), .link_mosi(mosi),
      .link_miso(miso_w));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // released lines toggle so no stale level passes for data
   always @(posedge sys_clk) flip <= ~flip;
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         end_of_test;
      end
   end
   // ==========
   // helpers
   function [7:0] crc8(input [7:0] dat);
      integer i;
      reg [7:0] c;
      begin
         c = 8'h00;
         for (i = 7; i >= 0; i = i - 1) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ dat[i]) ? 8'h07 : 8'h00);
         end
         crc8 = c;
      end
   endfunction
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [15:0] v);
      begin
         @(posedge sys_clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= v;
         @(posedge sys_clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [15:0] m, input [15:0] exp);
      begin
         @(posedge sys_clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge sys_clk);
         reg_rd <= 1'b0;
         #1 chk(reg_rdata & m, exp);
      end
   endtask
   task wait_rx;
      integer k;
      begin
         k = 0;
         while (rx_dma_req !== 1'b1 && k < 100) begin
            @(posedge sys_clk);
            k = k + 1;
         end
         chk({15'h0000, rx_dma_req}, 16'h0001);
      end
   endtask
   task end_of_test;
      begin
         if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
         end else begin
            $display("SIMULATION FAILED");
         end
         $finish;
      end
   endtask
   // ==========
   // sequence
   initial begin
      rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      flip = 1'b0;
      n_mismatch = 0;
      num_checks = 0;
      cyc = 0;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      rd(`SPDC_CTL0_ADDR, 16'hFFFF, `SPDC_CTL0_RST);
      rd(`SPDC_CTL1_ADDR, 16'hFFFF, `SPDC_CTL1_RST);
      rd(`SPDC_POLY_ADDR, 16'hFFFF, `SPDC_POLY_RST);
      rd(4'hF, 16'hFFFF, 16'h0000);
      rd(`SPDC_STAT_ADDR, 16'h01F3, 16'h0002);
      wr(`SPDC_CTL1_ADDR, 16'h00E3);
      wr(`SPDC_CTL0_ADDR, 16'h0040);
      #1 chk({14'h0000, tx_dma_req, irq}, 16'h0003);
      wr(`SPDC_DATA_ADDR, 16'h00A5);
      fork
         i_spdc_ext_master.frame(8'h3C, 8, 1'b0, q);
         begin
            repeat (20) @(posedge sys_clk);
            rd(`SPDC_STAT_ADDR, 16'h0080, 16'h0080);
         end
      join
      chk({8'h00, q}, 16'h00A5);
      wait_rx;
      rd(`SPDC_DATA_ADDR, 16'hFFFF, 16'h003C);
      i_spdc_ext_master.frame(8'h11, 8, 1'b0, q);
      wait_rx;
      i_spdc_ext_master.frame(8'h22, 8, 1'b0, q);
      repeat (8) @(posedge sys_clk);
      rd(`SPDC_STAT_ADDR, 16'h0041, 16'h0041);
      rd(`SPDC_DATA_ADDR, 16'hFFFF, 16'h0011);
      rd(`SPDC_STAT_ADDR, 16'h0000, 16'h0000);
      rd(`SPDC_STAT_ADDR, 16'h0040, 16'h0000);
      wr(`SPDC_CTL0_ADDR, 16'h0000);
      wr(`SPDC_CTL1_ADDR, 16'h0000);
      #1 chk({15'h0000, irq}, 16'h0000);
      wr(`SPDC_CTL0_ADDR, 16'h2000);
      wr(`SPDC_CTL0_ADDR, 16'h2040);
      wr(`SPDC_DATA_ADDR, 16'h0096);
      i_spdc_ext_master.frame(8'h5A, 8, 1'b1, q);
      repeat (8) @(posedge sys_clk);
      rd(`SPDC_DATA_ADDR, 16'hFFFF, 16'h005A);
      rd(`SPDC_RCRC_ADDR, 16'h00FF, {8'h00, crc8(8'h5A)});
      rd(`SPDC_TCRC_ADDR, 16'h00FF, {8'h00, crc8(8'h96)});
      wr(`SPDC_CTL0_ADDR, 16'h3040);
      i_spdc_ext_master.frame(~crc8(8'h5A), 8, 1'b0, q);
      chk({8'h00, q}, {8'h00, crc8(8'h96)});
      repeat (8) @(posedge sys_clk);
      rd(`SPDC_STAT_ADDR, 16'h0010, 16'h0010);
      wr(`SPDC_STAT_ADDR, 16'h0010);
      rd(`SPDC_STAT_ADDR, 16'h0010, 16'h0010);
      wr(`SPDC_STAT_ADDR, 16'h0000);
      rd(`SPDC_STAT_ADDR, 16'h0010, 16'h0000);
      wr(`SPDC_CTL0_ADDR, 16'h0000);
      rd(`SPDC_DATA_ADDR, 16'h0000, 16'h0000);
      wr(`SPDC_CTL0_ADDR, 16'h0244);
      repeat (4) @(posedge sys_clk);
      wr(`SPDC_CTL0_ADDR, 16'h0344);
      rd(`SPDC_CTL0_ADDR, 16'h0044, 16'h0000);
      rd(`SPDC_STAT_ADDR, 16'h0020, 16'h0020);
      wr(`SPDC_CTL0_ADDR, 16'h0300);
      rd(`SPDC_STAT_ADDR, 16'h0020, 16'h0000);
      wr(`SPDC_CTL1_ADDR, 16'h0030);
      wr(`SPDC_CTL0_ADDR, 16'h0040);
      i_spdc_ext_master.frame(8'hC3, 3, 1'b0, q);
      repeat (8) @(posedge sys_clk);
      rd(`SPDC_STAT_ADDR, 16'h0100, 16'h0100);
      chk({15'h0000, irq}, 16'h0001);
      wr(`SPDC_STAT_ADDR, 16'h0000);
      rd(`SPDC_STAT_ADDR, 16'h0100, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      end_of_test;
   end
endmodule // tb_spi_dma_crc_status_logic
